// ==== logic/cic_pkg.sv ====
// constants shared by the core interrupt controller files
// assumes a single core clock and an APB register port
package cic_pkg;
    localparam int NUM_IRQ = 24;
    localparam int NUM_NMI = 8;
    localparam int NUM_IN = 32;
    localparam int PRIO_W = 3;
    localparam int IDX_W = 5;
    localparam int VEC_W = 6;
    localparam int BANKS = 6;
    localparam int PER_BANK = 4;
    localparam int FIELD_W = 4;
    localparam int EDGE_POS = 3;
    localparam int HALF = 16;
    localparam int NMI_BASE = 24;
    localparam int CONC_BIT = 24;

    // ====================================================
    // register byte addresses
    localparam logic [7:0] ADDR_PEND_LOW = 8'h00;
    localparam logic [7:0] ADDR_PEND_HIGH = 8'h04;
    localparam logic [7:0] ADDR_PRIO_BASE = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [5:0] WORD_PRIO_BASE = 6'h02;

    // ====================================================
    // field positions and reset values
    localparam int CTRL_AUTOVEC = 0;
    localparam int CTRL_NMI_HOST = 1;
    localparam int ST_IRQ = 0;
    localparam int ST_NMI = 1;
    localparam int ST_LEVEL = 2;
    localparam int ST_VEC = 5;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;
    localparam logic EDGE_RESET = 1'b0;
    localparam logic AUTOVEC_RESET = 1'b1;
    localparam logic [NUM_IN-1:0] SYNC_IDLE = 32'hFFFFFFFF;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_ACCESS = 2'b01,
        APB_DONE = 2'b11
    } cic_apb_state_type;
endpackage

// ==== logic/cic_sync.sv ====
// two-flop synchroniser bank for asynchronous request pins
// assumes pins idle high; flops reset to the idle level
`timescale 1ns/1ps
module cic_sync #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    // ====================================================
    // per-bit stages
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic stage1_q;
            logic stage2_q;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage1_q <= 1'b1;
                    stage2_q <= 1'b1;
                end else begin
                    stage1_q <= asyncIn[gi];
                    stage2_q <= stage1_q;
                end
            end
            assign syncOut[gi] = stage2_q;
        end
    endgenerate
endmodule

// ==== logic/cic_arbiter.sv ====
// combinational priority arbiter over all pending requests
// assumes pending vector already gated for routing
`timescale 1ns/1ps
module cic_arbiter (
    input wire logic [cic_pkg::NUM_IN-1:0] pend,
    input wire logic [cic_pkg::NUM_IRQ*cic_pkg::PRIO_W-1:0] prioFlat,
    output logic winValid,
    output logic winNmi,
    output logic [cic_pkg::PRIO_W-1:0] winLevel,
    output logic [cic_pkg::IDX_W-1:0] winIndex
);
    // ====================================================
    // selection
    always_comb begin
        logic [cic_pkg::PRIO_W-1:0] lvl;
        lvl = cic_pkg::PRIO_OFF;
        winValid = 1'b0;
        winNmi = 1'b0;
        winLevel = cic_pkg::PRIO_OFF;
        winIndex = '0;
        for (int i = 0; i < cic_pkg::NUM_IRQ; i++) begin
            lvl = prioFlat[i*cic_pkg::PRIO_W +: cic_pkg::PRIO_W];
            // strict compare: lower position wins a tie
            if (pend[i] && lvl != cic_pkg::PRIO_OFF && lvl > winLevel) begin
                winValid = 1'b1;
                winLevel = lvl;
                winIndex = cic_pkg::IDX_W'(i);
            end
        end
        // non-maskable level above all, higher position wins
        for (int j = 0; j < cic_pkg::NUM_NMI; j++) begin
            if (pend[cic_pkg::NMI_BASE+j]) begin
                winValid = 1'b1;
                winNmi = 1'b1;
                winLevel = cic_pkg::PRIO_TOP;
                winIndex = cic_pkg::IDX_W'(cic_pkg::NMI_BASE + j);
            end
        end
    end
endmodule

// ==== logic/cic_top.sv ====
// core interrupt controller: 24 maskable and 8 non-maskable requests, APB registers
// assumes request pins active low and asynchronous; strap stable at reset release
// Operation
// - eight non-maskable inputs, always edge-detected
// - twenty-four maskable inputs, edge or level
// - write one acknowledges latched edge requests
// - maskable pending state always readable
// - priority zero disables a maskable input
// - levels one to seven, seven highest
// - non-maskable level above every maskable level
// - equal levels resolved by input position
// - automatic vector output can be switched
// - pending requests arbitrated continuously
// - inputs from peripherals, DMA, pins, concentrator
// - strap routes concentrator NMI to host
// - registers reachable over the register bus
// - slow request signals detected reliably
// - three-bit priority, trigger bit, four per register
// - falling edge sets; ignored until next edge
// - reset: priority zero, level-triggered
// - NMI seven highest, NMI zero lowest
`timescale 1ns/1ps
module cic_top (
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request inputs, active low; nmiOutStrap is an active-high routing strap
    input wire logic [cic_pkg::NUM_IRQ-1:0] irqReqN,
    input wire logic [cic_pkg::NUM_NMI-1:0] nmiReqN,
    input wire logic nmiOutStrap,
    // core side, plus the host NMI output
    output logic coreIrq,
    output logic coreNmi,
    output logic [cic_pkg::PRIO_W-1:0] coreLevel,
    output logic [cic_pkg::VEC_W-1:0] coreVector,
    output logic coreVecValid,
    output logic hostNmiN
);
    // ====================================================
    // declarations
    cic_pkg::cic_apb_state_type apbState_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [cic_pkg::NUM_IN-1:0] syncIn;
    logic [cic_pkg::NUM_IN-1:0] prevIn_q;
    logic [cic_pkg::NUM_IN-1:0] active;
    logic [cic_pkg::NUM_IN-1:0] fell;
    logic [cic_pkg::NUM_IN-1:0] edgeAll;
    logic [cic_pkg::NUM_IN-1:0] latch_q;
    logic [cic_pkg::NUM_IN-1:0] setMask;
    logic [cic_pkg::NUM_IN-1:0] ackMask;
    logic [cic_pkg::NUM_IN-1:0] ackEdge;
    logic [cic_pkg::NUM_IN-1:0] pending;
    logic [cic_pkg::NUM_IN-1:0] arbPend;
    logic [cic_pkg::NUM_IRQ*cic_pkg::PRIO_W-1:0] prio_q;
    logic [cic_pkg::NUM_IRQ-1:0] edgeMode_q;
    logic autoVec_q;
    logic strapDone_q;
    logic nmiToHost_q;
    logic wrDone;
    logic [5:0] word;
    logic winValid;
    logic winNmi;
    logic [cic_pkg::PRIO_W-1:0] winLevel;
    logic [cic_pkg::IDX_W-1:0] winIndex;
    logic coreIrq_q;
    logic coreNmi_q;
    logic [cic_pkg::PRIO_W-1:0] coreLevel_q;
    logic [cic_pkg::VEC_W-1:0] coreVector_q;
    logic coreVecValid_q;
    logic hostNmiN_q;
    logic [31:0] rdData;
    logic rdErr;

    // ====================================================
    // input synchronisation and edge detection
    cic_sync #(
        .W(cic_pkg::NUM_IN)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({nmiReqN, irqReqN}),
        .syncOut(syncIn)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevIn_q <= cic_pkg::SYNC_IDLE;
        end else begin
            prevIn_q <= syncIn;
        end
    end

    assign active = ~syncIn;
    // one pulse per falling edge however slow the source
    assign fell = prevIn_q & ~syncIn;
    assign edgeAll = {{cic_pkg::NUM_NMI{1'b1}}, edgeMode_q};

    // ====================================================
    // strap capture after reset release
    // sampled once; later strap changes have no effect
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapDone_q <= 1'b0;
            nmiToHost_q <= 1'b0;
        end else if (!strapDone_q) begin
            strapDone_q <= 1'b1;
            nmiToHost_q <= nmiOutStrap;
        end
    end

    // ====================================================
    // pending latches, set wins over acknowledge
    always_comb begin
        setMask = fell & edgeAll;
        if (nmiToHost_q) begin
            setMask[cic_pkg::CONC_BIT] = 1'b0;
        end
    end

    // acks aimed at level inputs leave a stale latch alone
    assign ackEdge = ackMask & edgeAll;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            latch_q <= '0;
        end else begin
            latch_q <= (latch_q & ~ackEdge) | setMask;
        end
    end

    // level inputs show the synchronised pin, edge inputs the latch
    assign pending = (edgeAll & latch_q) | (~edgeAll & active);
    assign arbPend = pending;

    // ====================================================
    // arbitration and core outputs
    cic_arbiter u_arb (
        .pend(arbPend),
        .prioFlat(prio_q),
        .winValid(winValid),
        .winNmi(winNmi),
        .winLevel(winLevel),
        .winIndex(winIndex)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            coreIrq_q <= 1'b0;
            coreNmi_q <= 1'b0;
            coreLevel_q <= cic_pkg::PRIO_OFF;
            coreVector_q <= '0;
            coreVecValid_q <= 1'b0;
        end else begin
            coreIrq_q <= winValid;
            coreNmi_q <= winNmi;
            coreLevel_q <= winLevel;
            coreVector_q <= autoVec_q ? {1'b0, winIndex} : '0;
            coreVecValid_q <= winValid & autoVec_q;
        end
    end

    // host sees the synced level and does its own edge handling
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hostNmiN_q <= 1'b1;
        end else begin
            hostNmiN_q <= ~(nmiToHost_q & active[cic_pkg::CONC_BIT]);
        end
    end

    // ====================================================
    // APB handshake: one wait state per transfer
    // pready high in the second access cycle, for one cycle only
    assign word = paddr[7:2];
    assign wrDone = (apbState_q == cic_pkg::APB_DONE) && psel && penable && pwrite;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            apbState_q <= cic_pkg::APB_IDLE;
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            case (apbState_q)
                cic_pkg::APB_IDLE: begin
                    if (psel && !penable) begin
                        apbState_q <= cic_pkg::APB_ACCESS;
                    end
                end
                cic_pkg::APB_ACCESS: begin
                    if (psel && penable) begin
                        apbState_q <= cic_pkg::APB_DONE;
                        pready_q <= 1'b1;
                        prdata_q <= pwrite ? 32'h00000000 : rdData;
                        pslverr_q <= rdErr;
                    end else if (!psel) begin
                        apbState_q <= cic_pkg::APB_IDLE;
                    end
                end
                cic_pkg::APB_DONE: begin
                    apbState_q <= cic_pkg::APB_IDLE;
                    pready_q <= 1'b0;
                    prdata_q <= '0;
                    pslverr_q <= 1'b0;
                end
                default: begin
                    apbState_q <= cic_pkg::APB_IDLE;
                    pready_q <= 1'b0;
                end
            endcase
        end
    end

    // ====================================================
    // read mux and address decode
    always_comb begin
        rdData = 32'h00000000;
        rdErr = 1'b0;
        if (word == cic_pkg::ADDR_PEND_LOW[7:2]) begin
            rdData[cic_pkg::HALF-1:0] = pending[cic_pkg::HALF-1:0];
        end else if (word == cic_pkg::ADDR_PEND_HIGH[7:2]) begin
            rdData[cic_pkg::HALF-1:0] = pending[cic_pkg::NUM_IN-1:cic_pkg::HALF];
        end else if (word >= cic_pkg::ADDR_PRIO_BASE[7:2] && word < cic_pkg::ADDR_CTRL[7:2]) begin
            for (int k = 0; k < cic_pkg::PER_BANK; k++) begin
                rdData[k*cic_pkg::FIELD_W +: cic_pkg::PRIO_W] =
                    prio_q[(int'(word - cic_pkg::WORD_PRIO_BASE)*cic_pkg::PER_BANK + k)*cic_pkg::PRIO_W
                    +: cic_pkg::PRIO_W];
                rdData[k*cic_pkg::FIELD_W + cic_pkg::EDGE_POS] =
                    edgeMode_q[int'(word - cic_pkg::WORD_PRIO_BASE)*cic_pkg::PER_BANK + k];
            end
        end else if (word == cic_pkg::ADDR_CTRL[7:2]) begin
            rdData[cic_pkg::CTRL_AUTOVEC] = autoVec_q;
            rdData[cic_pkg::CTRL_NMI_HOST] = nmiToHost_q;
        end else if (word == cic_pkg::ADDR_STATUS[7:2]) begin
            rdData[cic_pkg::ST_IRQ] = coreIrq_q;
            rdData[cic_pkg::ST_NMI] = coreNmi_q;
            rdData[cic_pkg::ST_LEVEL +: cic_pkg::PRIO_W] = coreLevel_q;
            rdData[cic_pkg::ST_VEC +: cic_pkg::VEC_W] = coreVector_q;
        end else begin
            rdErr = 1'b1;
        end
    end

    // ====================================================
    // acknowledge writes to the pending registers
    // clear lands at the edge that samples pready
    always_comb begin
        ackMask = '0;
        if (wrDone && word == cic_pkg::ADDR_PEND_LOW[7:2]) begin
            ackMask[cic_pkg::HALF-1:0] = pwdata[cic_pkg::HALF-1:0];
        end else if (wrDone && word == cic_pkg::ADDR_PEND_HIGH[7:2]) begin
            ackMask[cic_pkg::NUM_IN-1:cic_pkg::HALF] = pwdata[cic_pkg::HALF-1:0];
        end
    end

    // ====================================================
    // priority and trigger configuration
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prio_q <= {cic_pkg::NUM_IRQ{cic_pkg::PRIO_RESET}};
            edgeMode_q <= {cic_pkg::NUM_IRQ{cic_pkg::EDGE_RESET}};
        end else if (wrDone && word >= cic_pkg::ADDR_PRIO_BASE[7:2] && word < cic_pkg::ADDR_CTRL[7:2]) begin
            for (int k = 0; k < cic_pkg::PER_BANK; k++) begin
                prio_q[(int'(word - cic_pkg::WORD_PRIO_BASE)*cic_pkg::PER_BANK + k)*cic_pkg::PRIO_W
                    +: cic_pkg::PRIO_W] <= pwdata[k*cic_pkg::FIELD_W +: cic_pkg::PRIO_W];
                edgeMode_q[int'(word - cic_pkg::WORD_PRIO_BASE)*cic_pkg::PER_BANK + k] <=
                    pwdata[k*cic_pkg::FIELD_W + cic_pkg::EDGE_POS];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            autoVec_q <= cic_pkg::AUTOVEC_RESET;
        end else if (wrDone && word == cic_pkg::ADDR_CTRL[7:2]) begin
            autoVec_q <= pwdata[cic_pkg::CTRL_AUTOVEC];
        end
    end

    // ====================================================
    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign coreIrq = coreIrq_q;
    assign coreNmi = coreNmi_q;
    assign coreLevel = coreLevel_q;
    assign coreVector = coreVector_q;
    assign coreVecValid = coreVecValid_q;
    assign hostNmiN = hostNmiN_q;
endmodule

// ==== verification/cic_chk.sv ====
// assertions on the core interrupt controller top ports
// assumes binding onto cic_top, single clock domain
`timescale 1ns/1ps
module cic_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] nmiReqN,
    input wire logic nmiOutStrap,
    input wire logic coreIrq,
    input wire logic coreNmi,
    input wire logic [2:0] coreLevel,
    input wire logic [5:0] coreVector,
    input wire logic coreVecValid,
    input wire logic hostNmiN
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ============================================
    // bus answer
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_ready_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready timing");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
    // ============================================
    // core side
    property p_idle_level;
        !coreIrq |-> coreLevel == 3'h0 && !coreNmi;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("level without request");
    property p_nmi_level;
        coreNmi |-> coreIrq && coreLevel == 3'h7 && (!coreVecValid || coreVector >= 6'h18);
    endproperty
    a_nmi_level: assert property (p_nmi_level) else $error("nmi level or vector");
    property p_vec_off;
        coreIrq && !coreVecValid |-> coreVector == 6'h00;
    endproperty
    a_vec_off: assert property (p_vec_off) else $error("vector while disabled");
    property p_nmi_latency;
        $fell(nmiReqN[7]) |-> ##[3:6] coreNmi;
    endproperty
    a_nmi_latency: assert property (p_nmi_latency) else $error("nmi not raised");
    property p_sync_delay;
        $fell(nmiReqN[7]) && !coreIrq |=> !coreIrq [*2];
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("request too early");
    property p_host_route;
        $fell(nmiReqN[0]) && nmiOutStrap |-> ##[2:5] !hostNmiN;
    endproperty
    a_host_route: assert property (p_host_route) else $error("host nmi missing");
    c_nmi: cover property (coreNmi);
    c_err: cover property (pslverr);
    c_vec_off: cover property (coreIrq && !coreVecValid);
endmodule

bind cic_top cic_chk cic_chk_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .nmiReqN(nmiReqN), .nmiOutStrap(nmiOutStrap), .coreIrq(coreIrq), .coreNmi(coreNmi),
    .coreLevel(coreLevel), .coreVector(coreVector), .coreVecValid(coreVecValid), .hostNmiN(hostNmiN));

// ==== verification/cic_req_model.sv ====
// request pin model for peripherals, DMA, pins and concentrator
// assumes the bench sets irqLow and nmiLow at the rising edge
`timescale 1ns/1ps
module cic_req_model (
    input wire logic clk,
    input wire logic [cic_pkg::NUM_IRQ-1:0] irqLow,
    input wire logic [cic_pkg::NUM_NMI-1:0] nmiLow,
    output logic [cic_pkg::NUM_IRQ-1:0] irqReqN,
    output logic [cic_pkg::NUM_NMI-1:0] nmiReqN
);
    // ============================================
    // pins idle high, held low for whole cycles
    initial begin
        irqReqN = '1;
        nmiReqN = '1;
    end
    always @(posedge clk) begin
        irqReqN <= ~irqLow;
        nmiReqN <= ~nmiLow;
    end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the core interrupt controller
// assumes cic_chk is bound and cic_req_model drives the request pins
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic nmiOutStrap = 1'b0;
    logic [31:0] reqLow = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, coreIrq, coreNmi, coreVecValid, hostNmiN;
    logic [2:0] coreLevel;
    logic [5:0] coreVector;
    logic [23:0] irqReqN;
    logic [7:0] nmiReqN;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    cic_top cic_top_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqReqN(irqReqN),
        .nmiReqN(nmiReqN), .nmiOutStrap(nmiOutStrap), .coreIrq(coreIrq), .coreNmi(coreNmi), .coreLevel(coreLevel),
        .coreVector(coreVector), .coreVecValid(coreVecValid), .hostNmiN(hostNmiN));
    cic_req_model cic_req_model_i (.clk(clk), .irqLow(reqLow[23:0]), .nmiLow(reqLow[31:24]), .irqReqN(irqReqN),
        .nmiReqN(nmiReqN));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 4000) begin
            err_count++;
            summarize();
        end
    end
    // ============================================
    // shared tasks
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task summarize;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    task waitIrq(input logic want);
        int n;
        n = 0;
        while (coreIrq !== want && n < 12) begin
            @(posedge clk);
            n++;
        end
    endtask
    task doReset(input logic s);
        @(posedge clk);
        sys_rst <= 1'b1;
        nmiOutStrap <= s;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
    endtask
    // ============================================
    // scenarios
    task testReset;
        for (int i = 0; i < 6; i++) begin
            rdChk("prio", cic_pkg::ADDR_PRIO_BASE + 8'(4 * i), 32'h0);
        end
        rdChk("ctrl", cic_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, 8'h1C, 32'h0000FFFF);
        rdChk("bankF", 8'h1C, 32'h0000FFFF);
        apb(1'b1, 8'h1C, 32'h0);
        rdChk("unmapped", 8'h30, 32'h0);
        check("slverr", 32'(er), 32'h1);
        apb(1'b1, 8'h30, 32'hFFFFFFFF);
        check("wrErr", 32'(er), 32'h1);
    endtask
    task testLevel;
        reqLow <= 32'h20;
        repeat (6) @(posedge clk);
        check("masked", 32'(coreIrq), 32'h0);
        rdChk("pendLow", cic_pkg::ADDR_PEND_LOW, 32'h20);
        apb(1'b1, 8'h0C, 32'h30);
        waitIrq(1'b1);
        check("level", 32'(coreLevel), 32'h3);
        check("vector", 32'(coreVector), 32'h5);
        check("vecValid", 32'(coreVecValid), 32'h1);
        reqLow <= 32'h0;
        waitIrq(1'b0);
        rdChk("pendLow", cic_pkg::ADDR_PEND_LOW, 32'h0);
    endtask
    task testTie;
        apb(1'b1, 8'h08, 32'h700);
        apb(1'b1, 8'h0C, 32'h730);
        apb(1'b1, 8'h10, 32'h60);
        reqLow <= 32'h264;
        waitIrq(1'b1);
        check("tieVector", 32'(coreVector), 32'h2);
        check("tieLevel", 32'(coreLevel), 32'h7);
        apb(1'b1, cic_pkg::ADDR_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        check("noVector", {coreIrq, coreVecValid, coreVector}, 32'h80);
        apb(1'b1, cic_pkg::ADDR_CTRL, 32'h1);
        reqLow <= 32'h260;
        repeat (6) @(posedge clk);
        check("nextVector", 32'(coreVector), 32'h6);
        reqLow <= 32'h0;
        waitIrq(1'b0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 8'h08 + 8'(4 * i), 32'h0);
        end
    endtask
    task testEdge;
        apb(1'b1, 8'h18, 32'hD);
        reqLow <= 32'h10000;
        waitIrq(1'b1);
        check("edgeLevel", {coreLevel, coreVector}, 32'h150);
        rdChk("pendHigh", cic_pkg::ADDR_PEND_HIGH, 32'h1);
        apb(1'b1, cic_pkg::ADDR_PEND_HIGH, 32'h1);
        rdChk("acked", cic_pkg::ADDR_PEND_HIGH, 32'h0);
        repeat (6) @(posedge clk);
        check("heldLow", 32'(coreIrq), 32'h0);
        reqLow <= 32'h0;
        repeat (3) @(posedge clk);
        reqLow <= 32'h10000;
        waitIrq(1'b1);
        check("newEdge", 32'(coreIrq), 32'h1);
        reqLow <= 32'h0;
        apb(1'b1, cic_pkg::ADDR_PEND_HIGH, 32'h1);
        waitIrq(1'b0);
        apb(1'b1, 8'h18, 32'h0);
    endtask
    task testNmi;
        reqLow <= 32'h88000000;
        waitIrq(1'b1);
        check("nmi", {coreNmi, coreLevel, coreVector}, 32'h3DF);
        rdChk("status", cic_pkg::ADDR_STATUS, 32'h3FF);
        reqLow <= 32'h0;
        rdChk("nmiPend", cic_pkg::ADDR_PEND_HIGH, 32'h8800);
        apb(1'b1, cic_pkg::ADDR_PEND_HIGH, 32'h8000);
        repeat (4) @(posedge clk);
        check("nmiLow", 32'(coreVector), 32'h1B);
        apb(1'b1, cic_pkg::ADDR_PEND_HIGH, 32'h0800);
        waitIrq(1'b0);
        check("nmiDone", 32'(coreIrq), 32'h0);
    endtask
    task testStrap;
        doReset(1'b1);
        check("rstOut", {coreIrq, coreNmi, coreVecValid, hostNmiN}, 32'h1);
        rdChk("strap", cic_pkg::ADDR_CTRL, 32'h3);
        reqLow <= 32'h01000000;
        repeat (6) @(posedge clk);
        check("hostNmi", {hostNmiN, coreIrq}, 32'h0);
        reqLow <= 32'h0;
        rdChk("noLatch", cic_pkg::ADDR_PEND_HIGH, 32'h0);
        doReset(1'b0);
        rdChk("noStrap", cic_pkg::ADDR_CTRL, 32'h1);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        testReset();
        testLevel();
        testTie();
        testEdge();
        testNmi();
        testStrap();
        summarize();
    end
endmodule
